// ---- inc/cgoc_defs.vh ----
// Register map, field positions and reset values for the pin/opmode block
`ifndef CGOC_DEFS_VH
`define CGOC_DEFS_VH

`define CGOC_ADDR_OPMODE     8'h04
`define CGOC_ADDR_PINFUNC    8'h05
`define CGOC_ADDR_DIR        8'h07
`define CGOC_ADDR_DRIVE      8'h09
`define CGOC_ADDR_OUTLVL     8'h0B
`define CGOC_ADDR_INLVL      8'h0D

`define CGOC_RST_BYTE        8'h00
`define CGOC_RST_OSC         1'h0
`define CGOC_RST_DIV         4'h0
`define CGOC_RST_PAUSE       1'h0

`define CGOC_OP_CONT_BIT     7
`define CGOC_OP_MODE_HI      6
`define CGOC_OP_MODE_LO      5
`define CGOC_OP_OSC_BIT      4
`define CGOC_OP_DIV_HI       3
`define CGOC_OP_DIV_LO       0

`define CGOC_MODE_MANUAL     2'h0
`define CGOC_MODE_AUTO       2'h1
`define CGOC_MODE_TURBO      2'h2
`define CGOC_MODE_RSVD       2'h3

`endif

// ---- rtl/cgoc_top.v ----
// Channel pin configuration and operating mode register block
// Function
// - CRC fault policy applies only in autonomous and turbo modes
// - Policy bit clear: sequencing continues, pin setup kept on CRC fault
// - Policy bit set: fault forces all analog, pauses sequencing
// - After flag clears, sequencing resumes and pin setup is restored
// - Mode field: 00 manual, 01 autonomous, 10 turbo
// - Oscillator bit: 0 high-speed, 1 low-power
// - Four-bit divider field sets sampling speed
// - Pin function bit: 0 analog input, 1 general-purpose pin
// - Direction bit: 0 digital input, 1 digital output
// - Drive bit: 0 open-drain, 1 push-pull
// - Output level bit sets driven logic level
// - Input level reports all eight channel levels
//
// Behaviour notes
//  - The register port is a plain strobe interface behind the serial
//    configuration front end; a write lands on the edge that samples
//    the write strobe and the derived outputs follow one edge later.
//  - A read returns data registered on the edge that samples the read
//    strobe; the read data holds until the next read so the front end
//    may shift it out at its own pace.
//  - Writes and reads may come back to back; a read in the same cycle
//    as a write to the same offset returns the old value.
//  - Pin levels and the CRC fault flag arrive from outside this clock
//    domain and pass two flops before any logic uses them. The input
//    level register adds one more flop, so a pin change shows up in a
//    read about four edges after it happens.
//  - The CRC fault hold never touches the configuration registers. It
//    only masks what reaches the pins, so when the flag drops the old
//    pin setup comes back by itself with nothing to save or restore.
//  - The hold is gated by the mode field: manual conversions are host
//    paced and keep their pins even with the policy bit set.
//  - Mode code 11 is stored and read back as written, but the exported
//    mode shows manual so the sequencer never acts on an undefined code.
//  - Open-drain outputs never drive high: a 1 only releases the pin and
//    an outside pull-up has to supply the level.
//  - Channels that are not outputs are released with the data line low,
//    which keeps the pad from toggling while it is unused.
`include "cgoc_defs.vh"

module cgoc_top #(
    parameter NCH = 8
) (
    // Clock and reset
    input  wire             core_clk_i,
    input  wire             resetn_i,
    // Register port from the serial configuration interface
    input  wire             reg_wr_i,
    input  wire             reg_rd_i,
    input  wire [7:0]       reg_addr_i,
    input  wire [7:0]       reg_wdata_i,
    output reg  [7:0]       reg_rdata_o,
    // CRC fault flag from the interface logic
    input  wire             crc_err_flag_i,
    // Operating controls to the sequencer and timing
    output reg  [1:0]       conversion_mode_select_o,
    output reg              oscillator_select_o,
    output reg  [3:0]       clk_div_o,
    output reg              seq_pause_o,
    // Channel pins
    input  wire [NCH-1:0]   channel_pin_i,
    output reg  [NCH-1:0]   channel_pin_o,
    output reg  [NCH-1:0]   channel_pin_oen_o,
    output reg  [NCH-1:0]   channel_analog_o
);

    reg  [7:0]     opmode_q;
    reg  [NCH-1:0] pinfunc_q;
    reg  [NCH-1:0] dir_q;
    reg  [NCH-1:0] drive_q;
    reg  [NCH-1:0] outlvl_q;
    reg  [NCH-1:0] pin_meta_q;
    reg  [NCH-1:0] pin_sync_q;
    reg  [NCH-1:0] inlvl_q;
    reg            crc_meta_q;
    reg            crc_sync_q;

    wire [1:0] mode = opmode_q[`CGOC_OP_MODE_HI:`CGOC_OP_MODE_LO];
    wire       auto_like = (mode == `CGOC_MODE_AUTO) ||
                           (mode == `CGOC_MODE_TURBO);
    // Fault hold only when policy set; config regs untouched so restore is
    // automatic once the flag drops
    wire       fault_hold = auto_like && opmode_q[`CGOC_OP_CONT_BIT] &&
                            crc_sync_q;

    // Two-flop synchronisers for pins and the fault flag; only the second
    // stage is read, the first may go metastable when a level changes
    // close to the clock edge
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_meta_q <= {NCH{1'b0}};
            pin_sync_q <= {NCH{1'b0}};
            crc_meta_q <= 1'b0;
            crc_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= channel_pin_i;
            pin_sync_q <= pin_meta_q;
            crc_meta_q <= crc_err_flag_i;
            crc_sync_q <= crc_meta_q;
        end
    end

    // Register writes; input level and unmapped offsets ignore writes.
    // The pin level register is read only, so a host write there must
    // never disturb the sampled levels
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            opmode_q  <= `CGOC_RST_BYTE;
            pinfunc_q <= {NCH{1'b0}};
            dir_q     <= {NCH{1'b0}};
            drive_q   <= {NCH{1'b0}};
            outlvl_q  <= {NCH{1'b0}};
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `CGOC_ADDR_OPMODE:  opmode_q  <= reg_wdata_i;
                `CGOC_ADDR_PINFUNC: pinfunc_q <= reg_wdata_i[NCH-1:0];
                `CGOC_ADDR_DIR:     dir_q     <= reg_wdata_i[NCH-1:0];
                `CGOC_ADDR_DRIVE:   drive_q   <= reg_wdata_i[NCH-1:0];
                `CGOC_ADDR_OUTLVL:  outlvl_q  <= reg_wdata_i[NCH-1:0];
                default: ;
            endcase
        end
    end

    // Read mux; unmapped offsets read as zero so a stray probe of the
    // map never returns stale data
    reg  [7:0] rdata_d;
    always @* begin
        case (reg_addr_i)
            `CGOC_ADDR_OPMODE:  rdata_d = opmode_q;
            `CGOC_ADDR_PINFUNC: rdata_d = pinfunc_q;
            `CGOC_ADDR_DIR:     rdata_d = dir_q;
            `CGOC_ADDR_DRIVE:   rdata_d = drive_q;
            `CGOC_ADDR_OUTLVL:  rdata_d = outlvl_q;
            `CGOC_ADDR_INLVL:   rdata_d = inlvl_q;
            default:            rdata_d = `CGOC_RST_BYTE;
        endcase
    end

    // Read data registered on the edge that samples the read strobe and
    // held until the next read; input level adds one flop to the pin sync
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= `CGOC_RST_BYTE;
            inlvl_q     <= {NCH{1'b0}};
        end else begin
            inlvl_q <= pin_sync_q;
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_d;
            end
        end
    end

    // Next values of the operating controls; a reserved mode code is
    // exported as manual so the sequencer never runs an undefined mode
    reg  [1:0] mode_d;
    reg        osc_d;
    reg  [3:0] div_d;
    reg        pause_d;
    always @* begin
        osc_d   = opmode_q[`CGOC_OP_OSC_BIT];
        div_d   = opmode_q[`CGOC_OP_DIV_HI:`CGOC_OP_DIV_LO];
        pause_d = fault_hold;
        case (mode)
            `CGOC_MODE_MANUAL: mode_d = `CGOC_MODE_MANUAL;
            `CGOC_MODE_AUTO:   mode_d = `CGOC_MODE_AUTO;
            `CGOC_MODE_TURBO:  mode_d = `CGOC_MODE_TURBO;
            default:           mode_d = `CGOC_MODE_MANUAL;
        endcase
    end

    // Operating controls, registered so every output comes from a flop
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            conversion_mode_select_o <= `CGOC_MODE_MANUAL;
            oscillator_select_o      <= `CGOC_RST_OSC;
            clk_div_o                <= `CGOC_RST_DIV;
            seq_pause_o              <= `CGOC_RST_PAUSE;
        end else begin
            conversion_mode_select_o <= mode_d;
            oscillator_select_o      <= osc_d;
            clk_div_o                <= div_d;
            seq_pause_o              <= pause_d;
        end
    end

    // Per-channel pin drivers; oen low means the pin is driven. The fault
    // hold masks only the drivers, so pins fall back to analog inputs at
    // once and return to their setup when the hold ends
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            wire is_out = pinfunc_q[g] & dir_q[g] & ~fault_hold;
            always @(posedge core_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    channel_pin_o[g]     <= 1'b0;
                    channel_pin_oen_o[g] <= 1'b1;
                    channel_analog_o[g]  <= 1'b1;
                end else begin
                    channel_analog_o[g] <= ~pinfunc_q[g] | fault_hold;
                    if (!is_out) begin
                        channel_pin_o[g]     <= 1'b0;
                        channel_pin_oen_o[g] <= 1'b1;
                    end else if (drive_q[g]) begin
                        channel_pin_o[g]     <= outlvl_q[g];
                        channel_pin_oen_o[g] <= 1'b0;
                    end else begin
                        channel_pin_o[g]     <= 1'b0;
                        channel_pin_oen_o[g] <= outlvl_q[g];
                    end
                end
            end
        end
    endgenerate

endmodule

// ---- verif/cgoc_monitor.sv ----
// Port-level checker for the pin and operating mode block
module cgoc_monitor #(parameter NCH = 8) (
    input logic           core_clk_i, resetn_i, reg_wr_i, reg_rd_i,
    input logic           crc_err_flag_i, oscillator_select_o, seq_pause_o,
    input logic [7:0]     reg_addr_i, reg_wdata_i, reg_rdata_o,
    input logic [NCH-1:0] channel_pin_oen_o, channel_analog_o,
    input logic [1:0]     conversion_mode_select_o,
    input logic [3:0]     clk_div_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] w1_q, w2_q;
    // Write data two edges back: register lands, then outputs follow
    always @(posedge core_clk_i) {w2_q, w1_q} <= {w1_q, reg_wdata_i};
    wire op_wr = reg_wr_i && reg_addr_i == 8'h04;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // Flag and mode must settle past the two sync stages and the hold flop
    sequence s_quiet; !crc_err_flag_i [*4]; endsequence
    sequence s_manual; (conversion_mode_select_o == 2'h0) [*4]; endsequence
    a_read_unmapped: assert property (
        reg_rd_i && !(reg_addr_i inside {8'h04, 8'h05, 8'h07, 8'h09,
        8'h0B, 8'h0D}) |=> reg_rdata_o == 8'h00) else $error("unmapped");
    a_osc_follow: assert property (
        op_wr |-> ##2 oscillator_select_o == w2_q[4]) else $error("osc");
    a_div_follow: assert property (
        op_wr |-> ##2 clk_div_o == w2_q[3:0]) else $error("divider");
    a_mode_follow: assert property (
        op_wr && reg_wdata_i[6:5] != 2'h3 |-> ##2
        conversion_mode_select_o == w2_q[6:5]) else $error("mode");
    a_mode_rsvd: assert property (
        conversion_mode_select_o != 2'h3) else $error("reserved mode");
    a_analog_oen: assert property (
        (channel_analog_o & ~channel_pin_oen_o) == 0) else $error("drive");
    a_pause_all: assert property (
        seq_pause_o |-> &channel_analog_o && &channel_pin_oen_o)
        else $error("pause pins");
    a_manual_idle: assert property (
        s_manual |-> !seq_pause_o) else $error("manual pause");
    a_resume_clear: assert property (
        s_quiet |-> !seq_pause_o) else $error("no resume");
endmodule
bind cgoc_top cgoc_monitor #(.NCH(NCH)) u_cgoc_monitor (.core_clk_i,
    .resetn_i, .reg_wr_i, .reg_rd_i, .crc_err_flag_i, .oscillator_select_o,
    .seq_pause_o, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .channel_pin_oen_o,
    .channel_analog_o, .conversion_mode_select_o, .clk_div_o);

// ---- verif/cgoc_pin_model.sv ----
// Far side of the channel pins: outside drivers and pull-ups
module cgoc_pin_model (
    input  logic [7:0] channel_pin_o, channel_pin_oen_o, ext_en_i, ext_val_i,
    output logic [7:0] channel_pin_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released pin shows the outside driver, else the pull-up
    assign channel_pin_i = (~channel_pin_oen_o & channel_pin_o)
        | (channel_pin_oen_o & ((ext_en_i & ext_val_i) | ~ext_en_i));
endmodule

// ---- verif/cgoc_top_tb.sv ----
// Self-checking bench for the pin and operating mode block
module cgoc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic crc_err_flag_i = 1'b0, oscillator_select_o, seq_pause_o;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic [7:0] channel_pin_i, channel_pin_o, channel_pin_oen_o;
    logic [7:0] channel_analog_o;
    logic [1:0] conversion_mode_select_o;
    logic [3:0] clk_div_o;
    int err_count = 0, checked = 0;
    // Address, write data, read-back, value read straight after reset
    logic [31:0] rows [7] = '{32'h05FFFF00, 32'h073C3C00, 32'h090F0F00,
        32'h0BD4D400, 32'h0D0095BD, 32'h06770000, 32'h04E0E000};
    always #10 core_clk_i = ~core_clk_i;
    cgoc_top u_cgoc_top (.*);
    // Bits 2 to 5 are left free so the device drivers show on the pins
    cgoc_pin_model u_cgoc_pin_model (.*, .ext_en_i(8'hC3), .ext_val_i(8'h81));
    task chk(input logic [7:0] s, x);
        checked++;
        if (s !== x) begin
            err_count++;
            $display("BAD %0t seen %h exp %h", $time, s, x);
        end
    endtask
    task rdc(input logic [7:0] a, x);
        @(posedge core_clk_i) #1 {reg_rd_i, reg_addr_i} = {1'b1, a};
        @(posedge core_clk_i) #1 reg_rd_i = 1'b0;
        chk(reg_rdata_o, x);
    endtask
    task op(input logic [7:0] a, d, x);
        @(posedge core_clk_i) #1
            {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
        @(posedge core_clk_i) #1 reg_wr_i = 1'b0;
        repeat (3) @(posedge core_clk_i);
        rdc(a, x);
    endtask
    // Fault raised then cleared; five edges cover sync and hold delay
    task crcf(input logic [7:0] m, p, an);
        op(8'h04, m, m);
        crc_err_flag_i = 1'b1;
        repeat (5) @(posedge core_clk_i);
        #1 chk(seq_pause_o, p);
        chk(channel_analog_o, an);
        crc_err_flag_i = 1'b0;
        repeat (5) @(posedge core_clk_i);
        #1 chk(seq_pause_o, 8'h00);
        chk(channel_pin_oen_o, 8'hD3);
    endtask
    task end_sim;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge core_clk_i);
        #1 resetn_i = 1'b1;
        chk(channel_pin_oen_o & channel_analog_o, 8'hFF);
        foreach (rows[i]) rdc(rows[i][31:24], rows[i][7:0]);
        foreach (rows[i])
            op(rows[i][31:24], rows[i][23:16], rows[i][15:8]);
        chk(conversion_mode_select_o, 8'h00);
        chk(channel_pin_o, 8'h04);
        chk(channel_pin_oen_o, 8'hD3);
        chk(channel_analog_o, 8'h00);
        crcf(8'hA5, 8'h01, 8'hFF);
        crcf(8'h25, 8'h00, 8'h00);
        crcf(8'h80, 8'h00, 8'h00);
        crcf(8'hD3, 8'h01, 8'hFF);
        chk({conversion_mode_select_o, oscillator_select_o, clk_div_o},
            8'h53);
        end_sim;
    end
endmodule
